// File: scpd_pkg.sv
// constants for the serial control port and block power-down register
// assumes one 50 MHz system clock; all serial pins are asynchronous to it
package scpd_pkg;
	localparam int unsigned SCPD_CLK_HZ = 50000000;
	localparam int unsigned SCPD_ADDR_W = 10;
	localparam int unsigned SCPD_PDN_W = 13;
	localparam int unsigned SCPD_CNT_W = 6;
	localparam logic [9:0] SCPD_PDN_ADDR = 10'h1C3;
	localparam logic [12:0] SCPD_PDN_RESET = 13'h1FC0;
	// count value of the direction bit (bits 0..9 are address)
	localparam logic [5:0] SCPD_RW_SLOT = 6'h0A;
	// shortest complete write: address, direction and one register width
	localparam logic [5:0] SCPD_FULL_WR = 6'h18;
	localparam logic [5:0] SCPD_CNT_MAX = 6'h3F;
	// field positions of the power-down register
	localparam int unsigned SCPD_B_REGLO = 0;
	localparam int unsigned SCPD_B_REGCK = 1;
	localparam int unsigned SCPD_B_CONV_REG = 2;
	localparam int unsigned SCPD_B_BGAP_REG = 3;
	localparam int unsigned SCPD_B_COMMON = 4;
	localparam int unsigned SCPD_B_OUTCK = 5;
	localparam int unsigned SCPD_B_LOOPCK = 6;
	localparam int unsigned SCPD_B_TESTB = 7;
	localparam int unsigned SCPD_B_TESTA = 8;
	localparam int unsigned SCPD_B_INB = 9;
	localparam int unsigned SCPD_B_INA = 10;
	localparam int unsigned SCPD_B_DACB = 11;
	localparam int unsigned SCPD_B_DACA = 12;
	typedef enum logic [1:0] {SCPD_IDLE, SCPD_ADDR, SCPD_DATA} scpd_state_t;
endpackage

// File: scpd_serial_ctrl.sv
// four-wire serial control port slave holding the block power-down register
// assumes the shift clock is far slower than ref_clk (a few ref_clk per half period)
// assumes the host keeps each shift-clock half at least four ref_clk long
// only the 10-bit address form is decoded; other registers read back as zeros
// limitation: a write lands only once the host gives a trailing shift-clock edge
//
// Overview of operation
// - reset pin low restores register defaults
// - most blocks power down; one bit each
// - bits 0 to 5 reset to enabled
// - bits 6 to 12 reset to disabled
// - register read and written by serial address
// - enable seen high on rising edge starts frame
// - address sampled MSB first on rising edges
// - direction bit after address, one means write
// - write data MSB first, LSB last slot
// - only final register-width bits are kept
// - enable dropped ends the cycle
// - write shifts previous contents out MSB first
// - read data changes on falling clock edge
// - zeros after register bits until frame end
// - memory registers read back as zeros
module scpd_serial_ctrl import scpd_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reset_pin_n,
	input wire logic serial_clk,
	input wire logic serial_en,
	input wire logic serial_in,
	output logic serial_out,
	output logic [SCPD_PDN_W-1:0] block_power_controls,
	output logic converter_regulator_off,
	output logic bandgap_regulator_off
);
	// every flip-flop of the port sits in this one record; r_d is its next value
	typedef struct packed {
		// two-stage synchronisers for the asynchronous pins
		logic [1:0] clk_s;
		logic [1:0] en_s;
		logic [1:0] din_s;
		logic [1:0] rstn_s;
		logic clk_prev;

		// frame sequencer
		scpd_state_t state;
		logic [SCPD_CNT_W-1:0] cnt;
		logic [SCPD_ADDR_W-1:0] addr;
		logic wr;
		logic hit;

		// write capture and readback shifters
		logic [SCPD_PDN_W-1:0] shin;
		logic [SCPD_PDN_W-1:0] shout;
		logic dout;

		// the power-down register
		logic [SCPD_PDN_W-1:0] pdn;
	} scpd_regs_t;

	scpd_regs_t r_q;
	scpd_regs_t r_d;

	// shift-clock edges and pins as seen from ref_clk
	logic rise;
	logic fall;
	logic en;
	logic din;

	// pin reset as seen after its synchroniser
	logic pin_reset;

	// decodes of the frame position and shifter next values
	logic addr_hit;
	logic dir_slot;
	logic full_write;
	logic data_live;
	logic [SCPD_CNT_W-1:0] cnt_inc;
	logic [SCPD_PDN_W-1:0] shin_next;
	logic [SCPD_PDN_W-1:0] shout_next;

	always_comb begin
		r_d = r_q;

		// first stage of each synchroniser feeds only the second stage
		r_d.clk_s = {r_q.clk_s[0], serial_clk};
		r_d.en_s = {r_q.en_s[0], serial_en};
		r_d.din_s = {r_q.din_s[0], serial_in};
		r_d.rstn_s = {r_q.rstn_s[0], reset_pin_n};
		r_d.clk_prev = r_q.clk_s[1];

		rise = r_q.clk_s[1] & ~r_q.clk_prev;
		fall = ~r_q.clk_s[1] & r_q.clk_prev;
		en = r_q.en_s[1];
		din = r_q.din_s[1];
		pin_reset = ~r_q.rstn_s[1];

		addr_hit = (r_q.addr == SCPD_PDN_ADDR);
		dir_slot = (r_q.cnt == SCPD_RW_SLOT);
		// short write frames must leave the register untouched
		full_write = r_q.wr & r_q.hit & (r_q.cnt >= SCPD_FULL_WR);
		// the readback shifter moves only inside a data phase
		data_live = (r_q.state == SCPD_DATA) & en;
		cnt_inc = r_q.cnt + 6'h01;
		// only the last register-width bits survive, so zero padding falls off the top
		shin_next = {r_q.shin[SCPD_PDN_W-2:0], din};
		shout_next = {r_q.shout[SCPD_PDN_W-2:0], 1'b0};

		if (rise) begin
			unique case (r_q.state)
				// the edge that finds enable high also carries address bit 9
				SCPD_IDLE: begin
					if (en) begin
						r_d.state = SCPD_ADDR;
						r_d.addr = {{(SCPD_ADDR_W-1){1'b0}}, din};
						r_d.cnt = 6'h01;
					end
				end

				SCPD_ADDR: begin
					if (!en) begin
						// enable lost before the direction bit: the frame is dropped
						r_d.state = SCPD_IDLE;
					end else if (dir_slot) begin
						r_d.wr = din;
						r_d.hit = addr_hit;
						// other addresses, including memory registers, answer zeros here
						r_d.shout = addr_hit ? r_q.pdn : '0;
						r_d.shin = '0;
						r_d.state = SCPD_DATA;
						r_d.cnt = cnt_inc;
					end else begin
						// address shifts in MSB first
						r_d.addr = {r_q.addr[SCPD_ADDR_W-2:0], din};
						r_d.cnt = cnt_inc;
					end
				end

				SCPD_DATA: begin
					if (en) begin
						r_d.shin = shin_next;
						// the count saturates so very long packets still commit
						if (r_q.cnt != SCPD_CNT_MAX) begin
							r_d.cnt = cnt_inc;
						end
					end else begin
						// commit on the first trailing edge, short frames are dropped
						if (full_write) begin
							r_d.pdn = r_q.shin;
						end
						r_d.state = SCPD_IDLE;
					end
				end

				// the unused state code falls back to idle
				default: begin
					r_d.state = SCPD_IDLE;
				end
			endcase
		end

		// readback moves on falling edges so the host samples a settled bit
		if (fall) begin
			if (data_live) begin
				r_d.dout = r_q.shout[SCPD_PDN_W-1];
				r_d.shout = shout_next;
			end else begin
				// outside a data phase the pin rests low
				r_d.dout = 1'b0;
			end
		end

		if (pin_reset) begin
			// level action also covers the falling edge of the pin
			// a frame in flight is abandoned rather than completed
			r_d.pdn = SCPD_PDN_RESET;
			r_d.state = SCPD_IDLE;
			r_d.dout = 1'b0;
		end
	end

	// rst resets everything; the power-down register loads its default SCPD_PDN_RESET
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r_q <= '{
				clk_s: 2'h0,
				en_s: 2'h0,
				din_s: 2'h0,
				// the pin reads as released until its synchroniser has seen it low
				rstn_s: 2'h3,
				clk_prev: 1'b0,
				state: SCPD_IDLE,
				cnt: '0,
				addr: '0,
				wr: 1'b0,
				hit: 1'b0,
				shin: '0,
				shout: '0,
				dout: 1'b0,
				pdn: SCPD_PDN_RESET
			};
		end else begin
			r_q <= r_d;
		end
	end

	// data outputs come straight from flip-flops
	assign serial_out = r_q.dout;

	// one output per power-down bit
	for (genvar b = 0; b < SCPD_PDN_W; b++) begin : g_pdn
		assign block_power_controls[b] = r_q.pdn[b];
	end

	// named views of the two regulator bits
	assign converter_regulator_off = r_q.pdn[SCPD_B_CONV_REG];
	assign bandgap_regulator_off = r_q.pdn[SCPD_B_BGAP_REG];
endmodule

// File: scpd_host.sv
// host model driving the four-wire serial port, 5 ref_clk per shift-clock half
// assumes ref_clk runs; shift clock rests low outside frames
module scpd_host(
	output logic serial_clk,
	output logic serial_en,
	output logic serial_in,
	input wire logic ref_clk,
	input wire logic serial_out
);
	timeunit 1ns / 1ps;
	initial {serial_clk, serial_en, serial_in} = 3'h0;
	task automatic frame(input logic [31:0] v, input int n, output logic [31:0] got);
		got = '0;
		// three trailing clocks with enable low let the write commit
		for (int i = n - 1; i >= -3; i--) begin
			serial_en <= i >= 0;
			serial_in <= i >= 0 ? v[i] : 1'b0;
			repeat (5) @(posedge ref_clk);
			if (i >= 0)
				got = {got[30:0], serial_out};
			serial_clk <= 1'b1;
			repeat (5) @(posedge ref_clk);
			serial_clk <= 1'b0;
		end
	endtask
endmodule

// File: scpd_serial_ctrl_checker.sv
// assertions on the serial port pins and power-down register
// assumes shift-clock halves of 5 ref_clk
module scpd_checker(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reset_pin_n,
	input wire logic serial_clk,
	input wire logic serial_en,
	input wire logic serial_out,
	input wire logic converter_regulator_off,
	input wire logic bandgap_regulator_off,
	input wire logic [12:0] block_power_controls
);
	timeunit 1ns / 1ps;
	wire [12:0] pdn = block_power_controls;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_lo; $fell(rst) |-> pdn[5:0] == 6'h00; endproperty
	a_lo: assert property (p_lo) else $error("low bits reset");
	property p_hi; $fell(rst) |-> pdn[12:6] == 7'h7F; endproperty
	a_hi: assert property (p_hi) else $error("high bits reset");
	property p_pin; $fell(reset_pin_n) |-> ##[2:5] pdn == 13'h1FC0; endproperty
	a_pin: assert property (p_pin) else $error("pin reset");
	property p_cnv; converter_regulator_off == pdn[2]; endproperty
	a_cnv: assert property (p_cnv) else $error("converter flag");
	property p_bg; bandgap_regulator_off == pdn[3]; endproperty
	a_bg: assert property (p_bg) else $error("bandgap flag");
	// a write may only land once the frame is closed
	property p_cmt; $changed(pdn) |-> !serial_en || pdn == 13'h1FC0; endproperty
	a_cmt: assert property (p_cmt) else $error("commit in frame");
	property p_fall; $changed(serial_out) && serial_en && reset_pin_n |-> !serial_clk; endproperty
	a_fall: assert property (p_fall) else $error("out edge");
	property p_end; $fell(serial_en) |-> ##20 !serial_out; endproperty
	a_end: assert property (p_end) else $error("out after frame");
	c_wr: cover property ($changed(pdn) && reset_pin_n);
	c_out: cover property ($rose(serial_out));
	c_pin: cover property ($fell(reset_pin_n));
endmodule
bind scpd_serial_ctrl scpd_checker u_chk(.*);

// File: scpd_serial_ctrl_tb.sv
// self-checking bench for the serial port and power-down register
// assumes the host model and checker files are compiled first
module scpd_serial_ctrl_tb;
	timeunit 1ns / 1ps;
	logic ref_clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1, serial_clk, serial_en, serial_in, serial_out;
	logic converter_regulator_off, bandgap_regulator_off;
	logic [12:0] block_power_controls, prev = 13'h1FC0;
	// typical setting first, then single-core settings that keep core bits consistent, then all off and all on
	logic [12:0] rows [5] = '{13'h0180, 13'h0B80, 13'h1580, 13'h1FFF, 13'h0000};
	logic [31:0] got;
	int errors = 0, comparisons = 0, cyc = 0;
	scpd_serial_ctrl DUT(.*);
	scpd_host host(.*);
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 8000) begin
			errors++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test;
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (8) @(posedge ref_clk);
		foreach (rows[i]) begin
			host.frame({8'h00, 10'h1C3, 1'b1, rows[i]}, 24, got);
			chk("old", got[12:0], prev);
			chk("reg", block_power_controls, rows[i]);
			chk("flags", {bandgap_regulator_off, converter_regulator_off}, rows[i][3:2]);
			prev = rows[i];
		end
		host.frame({4'h0, 10'h1C3, 1'b0, 17'h0}, 28, got);
		chk("read", got[16:0], {prev, 4'h0});
		host.frame({6'h00, 10'h1C3, 1'b1, 2'b00, 13'h0A5A}, 26, got);
		chk("pad", block_power_controls, 13'h0A5A);
		host.frame({8'h00, 10'h1C4, 1'b1, 13'h1234}, 24, got);
		chk("addr", block_power_controls, 13'h0A5A);
		host.frame({12'h000, 10'h1C3, 1'b1, 9'h1FF}, 20, got);
		chk("abort", block_power_controls, 13'h0A5A);
		reset_pin_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("pin", block_power_controls, 13'h1FC0);
		reset_pin_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		end_of_test();
	end
endmodule
